// ### pkg/radio_misc_pkg.sv
// Constants shared by the misc configuration register slice
package radio_misc_pkg;

	// ----------------------------------------------------------------
	// Register port geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [5:0] ADDR_CARRIER_SENSE_OVERRIDE = 6'h2F;
	localparam logic [5:0] ADDR_MANUAL_CLOCK_OVERRIDE  = 6'h32;
	localparam logic [5:0] ADDR_MANUAL_CLOCK_GATE      = 6'h33;
	localparam logic [5:0] ADDR_SYNTH_LOCK_DELAY       = 6'h38;
	localparam logic [5:0] ADDR_SERIAL_BYTE0           = 6'h3C;
	localparam logic [5:0] ADDR_SERIAL_BYTE1           = 6'h3D;
	localparam logic [5:0] ADDR_SERIAL_BYTE2           = 6'h3E;
	localparam logic [5:0] ADDR_SERIAL_BYTE3           = 6'h3F;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CS_OVERRIDE_BIT = 7;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CARRIER_SENSE_OVERRIDE = 8'h00;
	localparam logic [7:0] RST_MANUAL_CLOCK_OVERRIDE  = 8'h00;
	localparam logic [7:0] RST_MANUAL_CLOCK_GATE      = 8'h00;
	localparam logic [7:0] RST_SYNTH_LOCK_DELAY       = 8'h64;
	localparam logic [7:0] READ_ZERO                  = 8'h00;

	// Arbitrary neutral value; a real part fuses its own code here
	localparam logic [31:0] FACTORY_SERIAL_DEFAULT    = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS    = 4000;
	localparam int LOCK_STEP_PS     = 2000000;
	localparam int LOCK_STEP_CYCLES = LOCK_STEP_PS / CLK_PERIOD_PS;
	localparam int STEP_CNT_W       = 9;

	// ----------------------------------------------------------------
	// Lock wait sequencer states, Gray along idle-wait-done
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LOCK_IDLE = 2'b00,
		LOCK_WAIT = 2'b01,
		LOCK_DONE = 2'b11
	} lock_state_e;

endpackage

// ### pkg/lock_timer_if.sv
// Connection between the register slice and the lock wait timer
`timescale 1ns/1ps
interface lock_timer_if;
	import radio_misc_pkg::*;

	logic       start;
	logic [7:0] steps;
	logic       expired;

	modport owner (output start, output steps, input expired);
	modport timer (input start, input steps, output expired);
endinterface

// ### src/lock_wait_timer.sv
// Synthesizer lock wait timer counting in 2 us steps
`timescale 1ns/1ps
module lock_wait_timer
	import radio_misc_pkg::*;
(
	input  wire logic    ref_clk,
	input  wire logic    nrst,
	lock_timer_if.timer  lt
);

	lock_state_e                  state;
	logic [STEP_CNT_W-1:0]        tick_cnt;
	logic [7:0]                   steps_left;

	localparam logic [STEP_CNT_W-1:0] TICK_LAST =
		STEP_CNT_W'(LOCK_STEP_CYCLES - 1);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// A new start always restarts the wait, even mid-count
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state      <= LOCK_IDLE;
			tick_cnt   <= '0;
			steps_left <= 8'h00;
		end else if (lt.start) begin
			tick_cnt   <= '0;
			steps_left <= lt.steps;
			state      <= (lt.steps == 8'h00) ? LOCK_DONE : LOCK_WAIT;
		end else begin
			case (state)
				LOCK_WAIT: begin
					if (tick_cnt == TICK_LAST) begin
						tick_cnt   <= '0;
						steps_left <= steps_left - 8'h01;
						if (steps_left == 8'h01)
							state <= LOCK_DONE;
					end else begin
						tick_cnt <= tick_cnt + 1'b1;
					end
				end
				LOCK_IDLE: state <= LOCK_IDLE;
				LOCK_DONE: state <= LOCK_DONE;
				default:   state <= LOCK_IDLE;
			endcase
		end
	end

	assign lt.expired = (state == LOCK_DONE);

endmodule

// ### src/radio_misc_config_regs.sv
// Misc configuration registers: carrier override, clocks, lock, serial
//
// Functional notes
// - Override bit 7 set forces carrier sense on, ignoring detection.
// - Carrier-sense override writes land only while analog unlock bit is one.
// - Automatic synth without lock signal waits count times 2 us; reset 0x64.
// - Serial code bytes return contents only while read-enable bit is set.
// - Serial code is read-only; writes to its four addresses change nothing.
// - Serial code byte order: lowest address bits 7:0, highest 31:24.
`timescale 1ns/1ps
module radio_misc_config_regs
	import radio_misc_pkg::*;
#(
	parameter logic [31:0] FACTORY_SERIAL = FACTORY_SERIAL_DEFAULT
)
(
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	// Byte register port behind the serial host interface
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	output logic      [DATA_W-1:0] reg_rdata,
	output logic                   reg_rvalid,
	// Gating bits held in the analog control register
	input  wire logic              csense_write_unlock,
	input  wire logic              serial_read_enable,
	// Synthesizer control from the control register and analog side
	input  wire logic              synth_manual,
	input  wire logic              use_pll_lock,
	input  wire logic              synth_start,
	input  wire logic              pll_lock,
	output logic                   synth_ready,
	// Carrier sense path
	input  wire logic              carrier_detected,
	output logic                   carrier_sense,
	// Clock override values to the clock tree
	output logic      [7:0]        clock_override_value,
	output logic      [7:0]        clock_gate_value,
	// Power hint to the serial code fuse block
	output logic                   serial_fuse_power
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// Only the override bit has a flop; reserved bits read zero
	logic       carrier_override;
	logic [7:0] manual_clock_override;
	logic [7:0] manual_clock_gate;
	logic [7:0] synth_lock_delay;
	logic [7:0] next_rdata;
	logic       auto_timed;

	// Start and step count out to the lock timer, expiry back
	lock_timer_if lt_bus ();

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	// Only bit 7 is kept; the reserved bits are not stored so a
	// careless write of ones cannot leak back on read
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			carrier_override <= RST_CARRIER_SENSE_OVERRIDE[CS_OVERRIDE_BIT];
		end else if (reg_wr && reg_addr == ADDR_CARRIER_SENSE_OVERRIDE
			&& csense_write_unlock) begin
			carrier_override <= reg_wdata[CS_OVERRIDE_BIT];
		end
	end

	// Clock registers reset to zero; software must reload them
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			manual_clock_override <= RST_MANUAL_CLOCK_OVERRIDE;
		end else if (reg_wr && reg_addr == ADDR_MANUAL_CLOCK_OVERRIDE) begin
			manual_clock_override <= reg_wdata;
		end
	end

	// Gate register, same reload duty after every reset
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			manual_clock_gate <= RST_MANUAL_CLOCK_GATE;
		end else if (reg_wr && reg_addr == ADDR_MANUAL_CLOCK_GATE) begin
			manual_clock_gate <= reg_wdata;
		end
	end

	// Lock delay count, reloaded to its default by reset
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			synth_lock_delay <= RST_SYNTH_LOCK_DELAY;
		end else if (reg_wr && reg_addr == ADDR_SYNTH_LOCK_DELAY) begin
			synth_lock_delay <= reg_wdata;
		end
	end

	// Serial code addresses have no write path at all

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = READ_ZERO;
		case (reg_addr)
			ADDR_CARRIER_SENSE_OVERRIDE:
				next_rdata = {carrier_override, 7'h00};
			ADDR_MANUAL_CLOCK_OVERRIDE:
				next_rdata = manual_clock_override;
			ADDR_MANUAL_CLOCK_GATE:
				next_rdata = manual_clock_gate;
			ADDR_SYNTH_LOCK_DELAY:
				next_rdata = synth_lock_delay;
			ADDR_SERIAL_BYTE0:
				next_rdata = FACTORY_SERIAL[7:0];
			ADDR_SERIAL_BYTE1:
				next_rdata = FACTORY_SERIAL[15:8];
			ADDR_SERIAL_BYTE2:
				next_rdata = FACTORY_SERIAL[23:16];
			ADDR_SERIAL_BYTE3:
				next_rdata = FACTORY_SERIAL[31:24];
			default:
				next_rdata = READ_ZERO;
		endcase
		// Fuses are unpowered without the enable, so they read blank
		if (reg_addr[5:2] == ADDR_SERIAL_BYTE0[5:2] && !serial_read_enable)
			next_rdata = READ_ZERO;
	end

	// Read data registered one cycle after the strobe; it holds
	// between reads so a slow host can sample it late
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			reg_rdata  <= READ_ZERO;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
				reg_rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Carrier sense and clock outputs
	// ----------------------------------------------------------------
	// Override only forces the indication on; detection still
	// reaches the output while the override is clear
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			carrier_sense <= 1'b0;
		end else begin
			carrier_sense <= carrier_override | carrier_detected;
		end
	end

	// Clock tree copy of the override register, one cycle behind
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			clock_override_value <= RST_MANUAL_CLOCK_OVERRIDE;
		end else begin
			clock_override_value <= manual_clock_override;
		end
	end

	// Clock tree copy of the gate register, one cycle behind
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			clock_gate_value <= RST_MANUAL_CLOCK_GATE;
		end else begin
			clock_gate_value <= manual_clock_gate;
		end
	end

	// Fuse power follows the read enable; a host that leaves the
	// enable set wastes power, and nothing here can stop it
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			serial_fuse_power <= 1'b0;
		end else begin
			serial_fuse_power <= serial_read_enable;
		end
	end

	// ----------------------------------------------------------------
	// Synthesizer lock wait
	// ----------------------------------------------------------------
	// Timer only matters in automatic mode without the lock signal;
	// in every other mode the analog lock indication is passed on
	assign auto_timed    = !synth_manual && !use_pll_lock;
	assign lt_bus.start  = synth_start && auto_timed;
	assign lt_bus.steps  = synth_lock_delay;

	// Count is latched at start, so a write to the lock delay
	// during a wait only affects the next one
	lock_wait_timer u_lock_wait_timer (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.lt      (lt_bus.timer)
	);

	// Ready is held low in the start cycle so a done left over from
	// the previous wait cannot slip through
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			synth_ready <= 1'b0;
		end else if (auto_timed) begin
			synth_ready <= lt_bus.expired && !synth_start;
		end else begin
			synth_ready <= pll_lock;
		end
	end

endmodule

// ### sim/radio_misc_monitor.sv
// Assertion checker for the misc configuration register slice
`timescale 1ns/1ps
module radio_misc_monitor
	import radio_misc_pkg::*;
#(
	parameter logic [31:0] FACTORY_SERIAL = 32'h0
)
(
	input wire logic              ref_clk,
	input wire logic              nrst,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic              reg_rvalid,
	input wire logic              csense_write_unlock,
	input wire logic              serial_read_enable,
	input wire logic              synth_manual,
	input wire logic              use_pll_lock,
	input wire logic              synth_start,
	input wire logic              pll_lock,
	input wire logic              synth_ready,
	input wire logic              carrier_detected,
	input wire logic              carrier_sense,
	input wire logic [7:0]        clock_override_value,
	input wire logic [7:0]        clock_gate_value,
	input wire logic              serial_fuse_power
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Serial code window is the top four byte addresses
	wire ser = reg_rd && reg_addr[5:2] == 4'hF;
	wire ovr = reg_wr && reg_addr == ADDR_CARRIER_SENSE_OVERRIDE;

	chk_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	chk_serial_gated: assert property (
		ser && !serial_read_enable |=> reg_rdata == 8'h00)
		else $error("serial byte leaked");
	chk_serial_order: assert property (ser && serial_read_enable |=>
		reg_rdata == 8'(FACTORY_SERIAL >> {$past(reg_addr[1:0]), 3'h0}))
		else $error("serial byte wrong");
	chk_override_sets: assert property (
		ovr && reg_wdata[7] && csense_write_unlock |-> ##2 carrier_sense)
		else $error("override write lost");
	chk_detect_path: assert property (carrier_detected |=> carrier_sense)
		else $error("detected carrier dropped");
	chk_reserved_zero: assert property (
		reg_rd && reg_addr == ADDR_CARRIER_SENSE_OVERRIDE |=>
		reg_rdata[6:0] == 7'h00)
		else $error("reserved bits nonzero");
	chk_lock_restart: assert property (
		synth_start && !synth_manual && !use_pll_lock |=> !synth_ready)
		else $error("ready after start");
	chk_ready_follows: assert property ((synth_manual || use_pll_lock) |=>
		synth_ready == $past(pll_lock))
		else $error("ready not following lock");
	chk_clock_copy: assert property (
		reg_wr && reg_addr == ADDR_MANUAL_CLOCK_OVERRIDE |-> ##2
		clock_override_value == $past(reg_wdata, 2))
		else $error("clock override not copied");
	chk_gate_copy: assert property (
		reg_wr && reg_addr == ADDR_MANUAL_CLOCK_GATE |-> ##2
		clock_gate_value == $past(reg_wdata, 2))
		else $error("clock gate not copied");
	chk_fuse_follows: assert property (
		1'b1 |=> serial_fuse_power == $past(serial_read_enable))
		else $error("fuse power not following enable");
	cover property (!synth_manual && !use_pll_lock && synth_ready);
	cover property (ser && serial_read_enable);
	cover property (synth_start && !synth_manual && !use_pll_lock);
	cover property (carrier_sense && !carrier_detected);
endmodule

// ### sim/radio_host.sv
// Host model driving the byte register port and gating bits
`timescale 1ns/1ps
module radio_host
	import radio_misc_pkg::*;
(
	input  wire logic ref_clk,
	output logic      reg_wr,
	output logic      reg_rd,
	output logic [5:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic      csense_write_unlock,
	output logic      serial_read_enable
);
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{csense_write_unlock, serial_read_enable} = '0;
	end
	// One-cycle strobe; lines inverted after so stale values never match
	task automatic xfer(input logic w, input logic [5:0] a,
		input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
		@(posedge ref_clk);
		#1;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
	endtask
	task automatic init_clocks();
		xfer(1'b1, ADDR_MANUAL_CLOCK_OVERRIDE, 8'h41);
		xfer(1'b1, ADDR_MANUAL_CLOCK_GATE, 8'h41);
	endtask
	// Unlock held through the write; reserved bits always zero
	task automatic set_override(input logic u, input logic on);
		csense_write_unlock = u;
		xfer(1'b1, ADDR_CARRIER_SENSE_OVERRIDE, {on, 7'h00});
		csense_write_unlock = 1'b0;
	endtask
	// Enable only around the reads, since it costs power
	task automatic read_serial();
		serial_read_enable = 1'b1;
		for (int i = 0; i < 4; i++) begin
			xfer(1'b0, ADDR_SERIAL_BYTE0 + 6'(i), 8'h00);
		end
		serial_read_enable = 1'b0;
	endtask
endmodule

// ### sim/radio_misc_config_regs_test.sv
// Self-checking bench for the misc configuration register slice
`timescale 1ns/1ps
module radio_misc_config_regs_test;
	import radio_misc_pkg::*;
	localparam logic [31:0] SERIAL = 32'hA1B2C3D4; // Arbitrary code
	logic ref_clk = 0;
	logic nrst, reg_wr, reg_rd, reg_rvalid, csense_write_unlock;
	logic serial_read_enable, synth_manual, use_pll_lock, synth_start;
	logic pll_lock, synth_ready, carrier_detected, carrier_sense;
	logic serial_fuse_power;
	logic [5:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, clock_override_value, clock_gate_value;
	logic [7:0] exp_q[$];
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n;

	radio_misc_config_regs #(.FACTORY_SERIAL(SERIAL)) u_dut (.ref_clk, .nrst,
		.reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
		.csense_write_unlock, .serial_read_enable, .synth_manual,
		.use_pll_lock, .synth_start, .pll_lock, .synth_ready,
		.carrier_detected, .carrier_sense, .clock_override_value,
		.clock_gate_value, .serial_fuse_power);
	radio_host u_host (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.csense_write_unlock, .serial_read_enable);

	always #2 ref_clk = ~ref_clk;

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.xfer(1'b0, a, 8'h00);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Read answers are matched in order; a hang is cut at the ceiling
	always @(posedge ref_clk) begin
		cycles++;
		if (reg_rvalid === 1'b1 && exp_q.size() > 0) begin
			chk("rdata", exp_q.pop_front(), reg_rdata);
		end else if (reg_rvalid === 1'b1) begin
			chk("rvalid", 1'b0, reg_rvalid);
		end
		if (cycles == 3000) begin
			bad_count++;
			test_done();
		end
	end

	initial begin
		{nrst, synth_manual, use_pll_lock, synth_start} = '0;
		{pll_lock, carrier_detected} = '0;
		void'($urandom(32'h5d37));
		repeat (6) @(posedge ref_clk);
		#1;
		nrst = 1;
		// Reset values and an unmapped hole
		rd(ADDR_CARRIER_SENSE_OVERRIDE, 8'h00);
		rd(ADDR_MANUAL_CLOCK_OVERRIDE, 8'h00);
		rd(ADDR_SYNTH_LOCK_DELAY, 8'h64);
		rd(6'h10, 8'h00);
		u_host.init_clocks();
		rd(ADDR_MANUAL_CLOCK_GATE, 8'h41);
		chk("gate", 8'h41, clock_gate_value);
		chk("ovr", 8'h41, clock_override_value);
		// Locked write dropped, unlocked one forces carrier sense
		u_host.set_override(1'b0, 1'b1);
		rd(ADDR_CARRIER_SENSE_OVERRIDE, 8'h00);
		chk("sense", 1'b0, carrier_sense);
		u_host.set_override(1'b1, 1'b1);
		rd(ADDR_CARRIER_SENSE_OVERRIDE, 8'h80);
		chk("sense", 1'b1, carrier_sense);
		u_host.set_override(1'b1, 1'b0);
		repeat (8) begin
			carrier_detected = 1'($urandom);
			@(posedge ref_clk);
			#1;
			chk("sense", carrier_detected, carrier_sense);
		end
		// Serial code: hidden, write-proof, then byte order
		for (int i = 0; i < 4; i++) begin
			rd(ADDR_SERIAL_BYTE0 + 6'(i), 8'h00);
			u_host.xfer(1'b1, ADDR_SERIAL_BYTE0 + 6'(i), 8'($urandom));
		end
		for (int i = 0; i < 4; i++) begin
			exp_q.push_back(SERIAL[8*i +: 8]);
		end
		u_host.read_serial();
		@(posedge ref_clk);
		#1;
		chk("fuse", 1'b0, serial_fuse_power);
		// Timed lock wait with one 2 us step
		u_host.xfer(1'b1, ADDR_SYNTH_LOCK_DELAY, 8'h01);
		synth_start = 1;
		@(posedge ref_clk);
		#1;
		synth_start = 0;
		n = 0;
		while (synth_ready !== 1'b1 && n < 1000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk("lock_wait", 16'h01F5, 16'(n));
		// Manual, then lock-signal mode: ready follows the lock line
		{synth_manual, use_pll_lock} = 2'h2;
		for (int i = 0; i < 8; i++) begin
			if (i == 4) {synth_manual, use_pll_lock} = 2'h1;
			pll_lock = 1'($urandom);
			@(posedge ref_clk);
			#1;
			chk("ready", pll_lock, synth_ready);
		end
		// Mid-run reset restores defaults; the host reloads the clocks
		nrst = 0;
		repeat (2) @(posedge ref_clk);
		#1;
		nrst = 1;
		chk("ready_rst", 1'b0, synth_ready);
		chk("ovr_rst", RST_MANUAL_CLOCK_OVERRIDE, clock_override_value);
		rd(ADDR_SYNTH_LOCK_DELAY, RST_SYNTH_LOCK_DELAY);
		rd(ADDR_MANUAL_CLOCK_GATE, RST_MANUAL_CLOCK_GATE);
		u_host.init_clocks();
		rd(ADDR_MANUAL_CLOCK_OVERRIDE, 8'h41);
		repeat (2) @(posedge ref_clk);
		chk("pending", 16'h0000, 16'(exp_q.size()));
		test_done();
	end
endmodule

bind radio_misc_config_regs radio_misc_monitor
	#(.FACTORY_SERIAL(FACTORY_SERIAL)) u_mon (.ref_clk, .nrst, .reg_wr,
	.reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
	.csense_write_unlock, .serial_read_enable, .synth_manual,
	.use_pll_lock, .synth_start, .pll_lock, .synth_ready,
	.carrier_detected, .carrier_sense, .clock_override_value,
	.clock_gate_value, .serial_fuse_power);
